/* File: hdl/rxc_defines.svh */
// constants of the reference and excitation control register bank
`ifndef RXC_DEFINES_SVH
`define RXC_DEFINES_SVH

// register indices; byte address is four times the index
`define RXC_IDX_REF        8'h05
`define RXC_IDX_MAG        8'h06
`define RXC_IDX_ROUTE      8'h07

// reset values
`define RXC_RST_REF        8'h10
`define RXC_RST_MAG        8'h00
`define RXC_RST_ROUTE      8'hff

// reference control fields
`define RXC_MON_HI         7
`define RXC_MON_LO         6
`define RXC_POSBUF_BIT     5
`define RXC_NEGBUF_BIT     4
`define RXC_SEL_HI         3
`define RXC_SEL_LO         2
`define RXC_PWR_HI         1
`define RXC_PWR_LO         0

// magnitude register fields
`define RXC_RAIL_BIT       7
`define RXC_SWITCH_BIT     6
`define RXC_MAG_HI         3
`define RXC_MAG_LO         0
`define RXC_MAG_WR_MASK    8'hcf

// routing register fields
`define RXC_R2_HI          7
`define RXC_R2_LO          4
`define RXC_R1_HI          3
`define RXC_R1_LO          0

// field codes
`define RXC_MON_OFF        2'h0
`define RXC_MON_LOW        2'h1
`define RXC_MON_THIRD      2'h2
`define RXC_MON_PULL       2'h3
`define RXC_PWR_OFF        2'h0
`define RXC_PWR_ON_PD      2'h1
`define RXC_PWR_ALWAYS     2'h2
`define RXC_SEL_INTERNAL   2'h2

// routing codes and pin vector positions
`define RXC_ROUTE_SIX_LAST 4'h5
`define RXC_ROUTE_PAIR_POS 4'h6
`define RXC_ROUTE_PAIR_NEG 4'h7
`define RXC_ROUTE_LAST_AIN 4'hb
`define RXC_ROUTE_COMMON   4'hc
`define RXC_ROUTE_FIRST_NC 4'hd
`define RXC_PIN_COUNT      15
`define RXC_PIN_COMMON     12
`define RXC_PIN_PAIR_POS   13
`define RXC_PIN_PAIR_NEG   14

// bus answers
`define RXC_RESP_OKAY      2'h0
`define RXC_RESP_SLVERR    2'h2

`endif

/* File: hdl/rxc_pkg.sv */
// types shared by the reference and excitation control register bank
package rxc_pkg;
  typedef logic [7:0]  rxc_byte_type;
  typedef logic [3:0]  rxc_route_code_type;
  typedef logic [14:0] rxc_pin_set_type;
endpackage

/* File: hdl/rxc_route_decode.sv */
// decode of one excitation source routing code into a one-hot pin set
`timescale 1ns/100ps
`include "rxc_defines.svh"

module rxc_route_decode
  import rxc_pkg::*;
#(
  parameter bit SIX_INPUT = 1'b0
)
(
  // routing code
  input  wire rxc_route_code_type code,
  // selected pin, one-hot or none
  output rxc_pin_set_type         pins
);

  //=============================================================
  // code to pin decode
  always_comb
  begin
    pins = '0;
    if (SIX_INPUT && (code == `RXC_ROUTE_PAIR_POS))
      pins[`RXC_PIN_PAIR_POS] = 1'b1;
    else if (SIX_INPUT && (code == `RXC_ROUTE_PAIR_NEG))
      pins[`RXC_PIN_PAIR_NEG] = 1'b1;
    else if (SIX_INPUT && (code > `RXC_ROUTE_PAIR_NEG) && (code <= `RXC_ROUTE_LAST_AIN))
      pins = '0;
    else if (code == `RXC_ROUTE_COMMON)
      pins[`RXC_PIN_COMMON] = 1'b1;
    else if (code <= `RXC_ROUTE_LAST_AIN)
      pins[code] = 1'b1;
    else
      pins = '0;
  end

endmodule // rxc_route_decode

/* File: hdl/rxc_regs.sv */
// reference and excitation control registers behind an AXI4-Lite slave
//=============================================================
// Behaviour
// - reference monitor field: off, low, low plus third-supply, low plus pull-together
// - positive reference buffer bit: zero active, one bypassed and disabled
// - negative reference buffer bit: same sense, resets to one
// - reference source field: first pair, second pair, internal; code three reserved
// - internal reference field: off, on except power-down, always on
// - top magnitude-register bit enables amplifier rail monitor, resets zero
// - low-side switch bit closes switch, forced open during power-down
// - two reserved magnitude-register bits read zero, software writes zero
// - four-bit magnitude sets one common current for both sources
// - upper routing nibble picks second source pin, resets all ones
// - lower routing nibble picks first source pin, same code map
// - six-input variant maps codes six, seven to second reference pair
// - reference control register at index 05h, resets to 10h
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "rxc_defines.svh"

module rxc_regs
  import rxc_pkg::*;
#(
  parameter int ADDR_W    = 10,
  parameter bit SIX_INPUT = 1'b0
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // device mode
  input  wire logic              powerDown,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // axi4-lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // reference controls
  output logic                   refLowMonitorEn,
  output logic                   refThirdSupplyMonitorEn,
  output logic                   refPullTogetherEn,
  output logic                   posRefBufferEn,
  output logic                   negRefBufferEn,
  output logic [1:0]             refSourceSelect,
  output logic                   internalRefOn,
  // excitation controls
  output logic                   ampRailMonitorEn,
  output logic                   lowSideSwitchClosed,
  output logic [3:0]             excitationMagnitude,
  output rxc_pin_set_type        firstSourcePins,
  output rxc_pin_set_type        secondSourcePins
);

  localparam int IDX_W = ADDR_W - 2;

  //=============================================================
  // state
  rxc_byte_type          ref_reg, ref_next;
  rxc_byte_type          mag_reg, mag_next;
  rxc_byte_type          route_reg, route_next;
  logic                  awHeld_reg, awHeld_next;
  logic [IDX_W-1:0]      awIdx_reg, awIdx_next;
  logic                  wHeld_reg, wHeld_next;
  rxc_byte_type          wData_reg, wData_next;
  logic                  wLane_reg, wLane_next;
  logic                  awready_reg, awready_next;
  logic                  wready_reg, wready_next;
  logic                  bvalid_reg, bvalid_next;
  logic [1:0]            bresp_reg, bresp_next;
  logic                  arready_reg, arready_next;
  logic                  rvalid_reg, rvalid_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic [1:0]            rresp_reg, rresp_next;
  logic [13:0]           ctl_reg, ctl_next;
  rxc_pin_set_type       pins1_reg, pins2_reg;
  rxc_pin_set_type       pins1Dec, pins2Dec;
  logic                  doWrite;
  logic [IDX_W-1:0]      arIdx;

  assign doWrite = awHeld_reg && wHeld_reg && !bvalid_reg;
  assign arIdx   = s_axi_araddr[ADDR_W-1:2];

  //=============================================================
  // routing decoders
  rxc_route_decode #(.SIX_INPUT(SIX_INPUT)) firstDecode
  (
    .code (route_reg[`RXC_R1_HI:`RXC_R1_LO]),
    .pins (pins1Dec)
  );

  rxc_route_decode #(.SIX_INPUT(SIX_INPUT)) secondDecode
  (
    .code (route_reg[`RXC_R2_HI:`RXC_R2_LO]),
    .pins (pins2Dec)
  );

  //=============================================================
  // next values
  always_comb
  begin
    ref_next     = ref_reg;
    mag_next     = mag_reg;
    route_next   = route_reg;
    awHeld_next  = awHeld_reg;
    awIdx_next   = awIdx_reg;
    wHeld_next   = wHeld_reg;
    wData_next   = wData_reg;
    wLane_next   = wLane_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    // address and data are taken independently, in either order
    if (s_axi_awvalid && awready_reg)
    begin
      awHeld_next = 1'b1;
      awIdx_next  = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && wready_reg)
    begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata[7:0];
      wLane_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (doWrite)
    begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = `RXC_RESP_OKAY;
      if (awIdx_reg == IDX_W'(`RXC_IDX_REF))
      begin
        if (wLane_reg)
          ref_next = wData_reg;
      end
      else if (awIdx_reg == IDX_W'(`RXC_IDX_MAG))
      begin
        if (wLane_reg)
          mag_next = wData_reg & `RXC_MAG_WR_MASK;
      end
      else if (awIdx_reg == IDX_W'(`RXC_IDX_ROUTE))
      begin
        if (wLane_reg)
          route_next = wData_reg;
      end
      else
        bresp_next = `RXC_RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && arready_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next  = `RXC_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      if (arIdx == IDX_W'(`RXC_IDX_REF))
        rdata_next[7:0] = ref_reg;
      else if (arIdx == IDX_W'(`RXC_IDX_MAG))
        rdata_next[7:0] = mag_reg;
      else if (arIdx == IDX_W'(`RXC_IDX_ROUTE))
        rdata_next[7:0] = route_reg;
      else
        rresp_next = `RXC_RESP_SLVERR;
    end
    awready_next = !awHeld_next && !bvalid_next;
    wready_next  = !wHeld_next && !bvalid_next;
    arready_next = !rvalid_next;
    // analog control decode
    ctl_next[0]    = ref_reg[`RXC_MON_HI:`RXC_MON_LO] != `RXC_MON_OFF;
    ctl_next[1]    = ref_reg[`RXC_MON_HI:`RXC_MON_LO] == `RXC_MON_THIRD;
    ctl_next[2]    = ref_reg[`RXC_MON_HI:`RXC_MON_LO] == `RXC_MON_PULL;
    ctl_next[3]    = !ref_reg[`RXC_POSBUF_BIT];
    ctl_next[4]    = !ref_reg[`RXC_NEGBUF_BIT];
    ctl_next[6:5]  = ref_reg[`RXC_SEL_HI:`RXC_SEL_LO];
    ctl_next[7]    = (ref_reg[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_ALWAYS)
                     || ((ref_reg[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_ON_PD)
                     && !powerDown);
    ctl_next[8]    = mag_reg[`RXC_RAIL_BIT];
    ctl_next[9]    = mag_reg[`RXC_SWITCH_BIT] && !powerDown;
    ctl_next[13:10] = mag_reg[`RXC_MAG_HI:`RXC_MAG_LO];
  end

  //=============================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ref_reg     <= `RXC_RST_REF;
      mag_reg     <= `RXC_RST_MAG;
      route_reg   <= `RXC_RST_ROUTE;
      awHeld_reg  <= 1'b0;
      awIdx_reg   <= '0;
      wHeld_reg   <= 1'b0;
      wData_reg   <= 8'h00;
      wLane_reg   <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RXC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `RXC_RESP_OKAY;
      ctl_reg     <= 14'h0018 & 14'h0008;
      pins1_reg   <= '0;
      pins2_reg   <= '0;
    end
    else
    begin
      ref_reg     <= ref_next;
      mag_reg     <= mag_next;
      route_reg   <= route_next;
      awHeld_reg  <= awHeld_next;
      awIdx_reg   <= awIdx_next;
      wHeld_reg   <= wHeld_next;
      wData_reg   <= wData_next;
      wLane_reg   <= wLane_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
      ctl_reg     <= ctl_next;
      pins1_reg   <= pins1Dec;
      pins2_reg   <= pins2Dec;
    end
  end

  //=============================================================
  // outputs
  assign s_axi_awready           = awready_reg;
  assign s_axi_wready            = wready_reg;
  assign s_axi_bvalid            = bvalid_reg;
  assign s_axi_bresp             = bresp_reg;
  assign s_axi_arready           = arready_reg;
  assign s_axi_rvalid            = rvalid_reg;
  assign s_axi_rdata             = rdata_reg;
  assign s_axi_rresp             = rresp_reg;
  assign refLowMonitorEn         = ctl_reg[0];
  assign refThirdSupplyMonitorEn = ctl_reg[1];
  assign refPullTogetherEn       = ctl_reg[2];
  assign posRefBufferEn          = ctl_reg[3];
  assign negRefBufferEn          = ctl_reg[4];
  assign refSourceSelect         = ctl_reg[6:5];
  assign internalRefOn           = ctl_reg[7];
  assign ampRailMonitorEn        = ctl_reg[8];
  assign lowSideSwitchClosed     = ctl_reg[9];
  assign excitationMagnitude     = ctl_reg[13:10];
  assign firstSourcePins         = pins1_reg;
  assign secondSourcePins        = pins2_reg;

  //=============================================================
  // checks
  sequence s_write_ref;
    doWrite && wLane_reg && (awIdx_reg == IDX_W'(`RXC_IDX_REF));
  endsequence

  sequence s_ref_lands;
    bvalid_reg && (ref_reg == $past(wData_reg));
  endsequence

  a_ref_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
    s_write_ref |=> s_ref_lands)
    else $error("reference control write not stored");

  a_ref_reset_value: assert property (@(posedge clk)
    !reset_n |=> (ref_reg == `RXC_RST_REF) && (route_reg == `RXC_RST_ROUTE))
    else $error("reset values wrong");

  a_mon_third_decode: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> refThirdSupplyMonitorEn
      == ($past(ref_reg[`RXC_MON_HI:`RXC_MON_LO]) == `RXC_MON_THIRD))
    else $error("third-supply monitor decode wrong");

  a_neg_buffer_follow: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> negRefBufferEn == !$past(ref_reg[`RXC_NEGBUF_BIT]))
    else $error("negative buffer enable wrong");

  a_intref_power_down: assert property (@(posedge clk) disable iff (!reset_n)
    (powerDown && ref_reg[`RXC_PWR_HI:`RXC_PWR_LO] == `RXC_PWR_ON_PD) |=> !internalRefOn)
    else $error("internal reference on during power-down");

  a_switch_power_down: assert property (@(posedge clk) disable iff (!reset_n)
    powerDown |=> !lowSideSwitchClosed)
    else $error("low-side switch closed during power-down");

  a_reserved_read_zero: assert property (@(posedge clk) disable iff (!reset_n)
    mag_reg[5:4] == 2'h0)
    else $error("reserved magnitude bits not zero");

  a_magnitude_out: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> excitationMagnitude == $past(mag_reg[`RXC_MAG_HI:`RXC_MAG_LO]))
    else $error("magnitude output wrong");

  a_route_common_pin: assert property (@(posedge clk) disable iff (!reset_n)
    (route_reg[`RXC_R1_HI:`RXC_R1_LO] == `RXC_ROUTE_COMMON)
      |=> firstSourcePins[`RXC_PIN_COMMON] && $onehot(firstSourcePins))
    else $error("first source not on common input");

  a_route_nc_off: assert property (@(posedge clk) disable iff (!reset_n)
    (route_reg[`RXC_R2_HI:`RXC_R2_LO] >= `RXC_ROUTE_FIRST_NC) |=> secondSourcePins == '0)
    else $error("second source connected on unused code");

  a_route_six_pair: assert property (@(posedge clk) disable iff (!reset_n)
    (SIX_INPUT && route_reg[`RXC_R2_HI:`RXC_R2_LO] == `RXC_ROUTE_PAIR_NEG)
      |=> secondSourcePins[`RXC_PIN_PAIR_NEG] && $onehot(secondSourcePins))
    else $error("six-input pair routing wrong");

endmodule // rxc_regs

/* File: verification/rxc_regs_bench.sv */
// self-checking testbench of the reference and excitation control register bank
`timescale 1ns/100ps
`include "rxc_defines.svh"

module rxc_regs_bench import rxc_pkg::*;;
  //==========================================================
  // signals
  logic        clk, reset_n, powerDown;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, refSourceSelect;
  logic        refLowMonitorEn, refThirdSupplyMonitorEn, refPullTogetherEn;
  logic        posRefBufferEn, negRefBufferEn, internalRefOn;
  logic        ampRailMonitorEn, lowSideSwitchClosed;
  logic [3:0]  excitationMagnitude;
  rxc_pin_set_type firstSourcePins, secondSourcePins, sixSecondPins;
  int          failures, n_compared, cycles;

  //==========================================================
  // devices: twelve-input and six-input variants on one bus
  rxc_regs #(.ADDR_W(10), .SIX_INPUT(1'b0)) DUT (
    .clk(clk), .reset_n(reset_n), .powerDown(powerDown),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .refLowMonitorEn(refLowMonitorEn), .refThirdSupplyMonitorEn(refThirdSupplyMonitorEn),
    .refPullTogetherEn(refPullTogetherEn), .posRefBufferEn(posRefBufferEn),
    .negRefBufferEn(negRefBufferEn), .refSourceSelect(refSourceSelect),
    .internalRefOn(internalRefOn), .ampRailMonitorEn(ampRailMonitorEn),
    .lowSideSwitchClosed(lowSideSwitchClosed), .excitationMagnitude(excitationMagnitude),
    .firstSourcePins(firstSourcePins), .secondSourcePins(secondSourcePins));

  rxc_regs #(.ADDR_W(10), .SIX_INPUT(1'b1)) DUT_SIX (
    .clk(clk), .reset_n(reset_n), .powerDown(powerDown),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot), .s_axi_rvalid(),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(), .s_axi_rresp(), .refLowMonitorEn(),
    .refThirdSupplyMonitorEn(), .refPullTogetherEn(), .posRefBufferEn(),
    .negRefBufferEn(), .refSourceSelect(), .internalRefOn(), .ampRailMonitorEn(),
    .lowSideSwitchClosed(), .excitationMagnitude(), .firstSourcePins(),
    .secondSourcePins(sixSecondPins));

  //==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axiWrite(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axiRead(input logic [9:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // register index to byte address is times four
  task automatic regWrite(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axiWrite({idx, 2'b00}, d, 4'h1, r);
    repeat (2) @(posedge clk);
  endtask

  task automatic regRead(input logic [7:0] idx, output logic [31:0] d);
    logic [1:0] r;
    axiRead({idx, 2'b00}, d, r);
  endtask

  task automatic setPowerDown(input logic pd);
    @(posedge clk);
    powerDown <= pd;
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [14:0] expPins(input logic [3:0] c, input bit six);
    expPins = '0;
    if (six && (c == 4'h6 || c == 4'h7)) expPins[c + 4'h7] = 1'b1;
    else if (!(six && c >= 4'h8 && c <= 4'hb) && c <= 4'hc) expPins[c] = 1'b1;
  endfunction

  //==========================================================
  // scenarios
  task automatic testResetValues;
    logic [31:0] d;
    check("posbuf", posRefBufferEn, 1'b1);
    check("negbuf", negRefBufferEn, 1'b0);
    check("monlow", refLowMonitorEn, 1'b0);
    check("ref_source_select", refSourceSelect, 2'h0);
    check("intref", internalRefOn, 1'b0);
    check("rail", ampRailMonitorEn, 1'b0);
    check("switch", lowSideSwitchClosed, 1'b0);
    check("mag", excitationMagnitude, 4'h0);
    check("pins1", firstSourcePins, 15'h0);
    check("pins2", secondSourcePins, 15'h0);
    regRead(`RXC_IDX_REF, d);
    check("refreg", d, 32'h10);
    regRead(`RXC_IDX_MAG, d);
    check("magreg", d, 32'h0);
    regRead(`RXC_IDX_ROUTE, d);
    check("routereg", d, 32'hff);
  endtask

  task automatic testRefFields;
    logic [7:0]  v;
    logic [31:0] d;
    for (int i = 0; i < 4; i++)
    begin
      // both buffers bypassed whenever the internal reference is chosen
      v = {i[1:0], i[1] | i[0], i[1], i[1:0], i[1:0]};
      regWrite(`RXC_IDX_REF, v);
      regRead(`RXC_IDX_REF, d);
      check("refreg", d, {24'h0, v});
      for (int pd = 0; pd < 2; pd++)
      begin
        setPowerDown(pd[0]);
        check("monlow", refLowMonitorEn, i != 0);
        check("monthird", refThirdSupplyMonitorEn, i == 2);
        check("monpull", refPullTogetherEn, i == 3);
        check("posbuf", posRefBufferEn, !(i[1] | i[0]));
        check("negbuf", negRefBufferEn, !i[1]);
        check("ref_source_select", refSourceSelect, i[1:0]);
        check("intref", internalRefOn, i == 2 || (i == 1 && pd == 0));
      end
    end
    setPowerDown(1'b0);
  endtask

  task automatic testMagnitude;
    logic [31:0] d;
    regWrite(`RXC_IDX_REF, 8'h12);
    regWrite(`RXC_IDX_MAG, 8'hff);
    regRead(`RXC_IDX_MAG, d);
    check("magreg", d, 32'hcf);
    check("rail", ampRailMonitorEn, 1'b1);
    check("switch", lowSideSwitchClosed, 1'b1);
    setPowerDown(1'b1);
    check("switchpd", lowSideSwitchClosed, 1'b0);
    check("railpd", ampRailMonitorEn, 1'b1);
    setPowerDown(1'b0);
    check("switch", lowSideSwitchClosed, 1'b1);
    for (int m = 0; m < 16; m++)
    begin
      regWrite(`RXC_IDX_MAG, {4'h0, m[3:0]});
      check("mag", excitationMagnitude, m[3:0]);
      check("rail", ampRailMonitorEn, 1'b0);
      check("switch", lowSideSwitchClosed, 1'b0);
    end
  endtask

  task automatic testRouting;
    for (int c = 0; c < 16; c++)
    begin
      regWrite(`RXC_IDX_ROUTE, {c[3:0], ~c[3:0]});
      check("pins2", secondSourcePins, expPins(c[3:0], 1'b0));
      check("pins1", firstSourcePins, expPins(~c[3:0], 1'b0));
      check("sixpins2", sixSecondPins, expPins(c[3:0], 1'b1));
    end
  endtask

  task automatic testUnmapped;
    logic [31:0] d;
    logic [1:0]  r;
    // protection attributes are ignored; run the rest with them all set
    @(posedge clk);
    s_axi_awprot <= 3'h7;
    s_axi_arprot <= 3'h7;
    axiWrite(10'h020, 8'h55, 4'h1, r);
    check("wrresp", r, `RXC_RESP_SLVERR);
    axiRead(10'h000, d, r);
    check("rdresp", r, `RXC_RESP_SLVERR);
    check("rddata", d, 32'h0);
    axiWrite(10'h014, 8'hab, 4'h0, r);
    check("nostrb", r, `RXC_RESP_OKAY);
    regRead(`RXC_IDX_REF, d);
    check("refkept", d, 32'h12);
  endtask

  //==========================================================
  // clock, watchdog and main sequence
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    {reset_n, powerDown, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_awprot = '0;
    s_axi_arprot = '0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    testResetValues();
    testRefFields();
    testMagnitude();
    testRouting();
    testUnmapped();
    results();
  end
endmodule // rxc_regs_bench
